// >>> ee_mst_model.sv
/*
  Behavioural two-wire bus master facing the EEPROM target.
  Assumes an open-drain data wire with a pull-up built by the bench.
*/
`timescale 1ns/100ps

module ee_mst_model (
  output logic      scl,     // Serial clock, high and still between frames
  output logic      sda_oe,  // High while the master pulls data low
  input  wire logic sda      // Wire level after the pull-up
);
  localparam real Q = 3.75;  // Quarter of the 15 ns link period
  localparam real H = 20.0;  // Hold around start and stop, above 3 system clocks

  initial begin
    scl    = 1'b1;
    sda_oe = 1'b0;
  end

  // ----------------------------------------------------------------
  // Bit and framing tasks
  // ----------------------------------------------------------------
  // One clock; data moves only while the clock is low
  task automatic bit_io(input logic b, output logic s);
    scl = 1'b0;
    #Q sda_oe = !b;  // A one releases the line
    #Q scl = 1'b1;
    s = sda;         // Taken on the rising edge
    #(2*Q);
  endtask

  // Data falls while the clock is high
  task automatic start();
    scl = 1'b0;
    #Q sda_oe = 1'b0;  // Released first, the target may still hold it
    #Q scl = 1'b1;
    #H sda_oe = 1'b1;
    #H;
  endtask

  // Data rises while the clock is high
  task automatic stop();
    scl = 1'b0;
    #Q sda_oe = 1'b1;
    #Q scl = 1'b1;
    #H sda_oe = 1'b0;
    #H;
  endtask

  // Start followed directly by stop, no clock between
  task automatic cancel();
    start();
    sda_oe = 1'b0;
    #H;
  endtask

  // Free clocks with the line released, used around reset
  task automatic clocks(input int n);
    repeat (n) begin
      scl = 1'b0;
      #(2*Q) scl = 1'b1;
      #(2*Q);
    end
  endtask

  // Eight bits MSB first, ninth clock returns the answer
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, ack);
  endtask

  // Receive a byte; a high answer ends the read
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(nack, s);
  endtask
endmodule

// >>> ee_pkg.sv
/*
  Types of the serial EEPROM target: FSM states and state carriers.
  Assumes ee_regs.svh is on the include path.
*/
`include "ee_regs.svh"

package ee_pkg;

  // ----------------------------------------------------------------
  // Link FSM states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [9:0] {
    ST_IDLE  = 10'h001,  // Waiting for a start
    ST_ADDR  = 10'h002,  // Slave address bits
    ST_AACK  = 10'h004,  // Address acknowledge slot
    ST_WADDR = 10'h008,  // Word address bits
    ST_WACK  = 10'h010,  // Word address acknowledge
    ST_WDATA = 10'h020,  // Write data bits
    ST_DACK  = 10'h040,  // Write data acknowledge
    ST_RDATA = 10'h080,  // Read data bits out
    ST_RACK  = 10'h100,  // Master acknowledge of read data
    ST_WAIT  = 10'h200   // Ignore all until next start
  } ee_state_t;

  // ----------------------------------------------------------------
  // State carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    ee_state_t                 state;
    logic [2:0]                cnt;
    logic [7:0]                shreg;
    logic [`EE_ADDR_W-1:0]     addr;
    logic                      rw;
    logic                      ack;
    logic                      sda_hi;
    logic                      first_done;
    logic                      cancel;
    logic                      wpend;
  } ee_link_t;

  typedef struct packed {
    logic drive_low;  // Pull data line low
    logic st_pend;    // Start seen during last high phase
  } ee_drv_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
    logic wpend;
  } ee_csmp_t;

  typedef struct packed {
    logic busy;
    logic wp;
    logic ce;
    logic rst;
  } ee_lsmp_t;

  typedef struct packed {
    logic scl_p;
    logic sda_p;
    logic fell;
  } ee_clk_t;

endpackage

// >>> ee_regs.svh
/*
  Constants of the serial EEPROM target: widths, timing, encodings.
  Assumes a 200 MHz system clock; included by package, top and write timer.
*/
`ifndef EE_REGS_SVH
`define EE_REGS_SVH

// ----------------------------------------------------------------
// Byte framing
// ----------------------------------------------------------------
`define EE_BYTE_BITS   8
`define EE_LAST_BIT    3'h7
`define EE_ADDR_W      8
`define EE_RW_READ     1'b1

// ----------------------------------------------------------------
// Internal write time
// ----------------------------------------------------------------
`define EE_WR_TIME_MS  5
`define EE_CLK_KHZ     200000
`define EE_WR_CYCLES   (`EE_WR_TIME_MS * `EE_CLK_KHZ)

`endif

// >>> ee_sync.sv
/*
  Two-flop level synchroniser of parametric width.
  Assumes each bit is an independent level, stable for several clocks.
*/
`timescale 1ns/100ps

module ee_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  // ----------------------------------------------------------------
  // Flop pair; first stage is read only by the second
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } ee_sync_st_t;

  ee_sync_st_t st;       // Both stages
  ee_sync_st_t next_st;  // Next value

  // No reset and no enable: it must pass reset and enable itself
  always_comb begin
    next_st.meta = d;
    next_st.stab = st.meta;
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign q = st.stab;
endmodule

// >>> ee_top.sv
/*
  Serial EEPROM target: two-wire link, reads, acknowledge polling,
  write-protect cancel and start/stop command cancel.
  Assumes scl is the master's serial clock, sda is open drain with a
  pull-up outside, and clk is a free-running 200 MHz system clock.
*/
`timescale 1ns/100ps
`include "ee_regs.svh"

// Overview of operation
// - Random read returns byte at supplied address
// - Current read uses internal address register
// - Current read after read: last address plus one
// - Master ack without stop: next byte follows
// - Nack then stop ends any read
// - Nine starts then command: device recovers
// - During internal write ignore, never acknowledge
// - Polling: ack low when write done, else high
// - Protect pin ignored until first data lsb
// - Protect high after that aborts write
// - Aborted write returns to standby at once
// - Start then stop cancels the command
// - Read cancel leaves address undefined
// - Data line only pulled low or released
// - Address lsb: one read, zero write
// - Eight-bit bytes, ninth clock acknowledges
module ee_top import ee_pkg::*; #(
  parameter int unsigned WR_CYCLES = `EE_WR_CYCLES,
  parameter logic [3:0]  DEV_CODE  = 4'h5  // Arbitrary value
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       wp,
  input  wire logic [2:0] dev_sel,
  output logic            wr_busy
);
  localparam int DEPTH = 2 ** `EE_ADDR_W;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ee_link_t lk;        // Link state, rising scl
  ee_link_t next_lk;   // Next link state
  ee_drv_t  dv;        // Drive state, falling scl
  ee_drv_t  next_dv;   // Next drive state
  ee_clk_t  cq;        // System clock state
  ee_clk_t  next_cq;   // Next system state
  ee_csmp_t cs;        // Pins and link flag seen by clk
  ee_lsmp_t ls;        // System levels seen by scl

  logic [7:0] mem [DEPTH];   // Array contents
  logic       mem_we;        // Store received byte
  logic [7:0] wdata;         // Byte just completed
  logic       busy;          // Internal write running
  logic       stop_evt;      // Stop seen by clk
  logic       start_evt;     // Start seen by clk
  logic       tm_start;      // Begin internal write
  logic [2:0] sel_s;         // Device select, stable

  localparam ee_link_t LK_RST = '{state: ST_IDLE, default: '0};
  localparam ee_clk_t  CK_RST = '{scl_p: 1'b1, sda_p: 1'b1, fell: 1'b0};

  // ----------------------------------------------------------------
  // Crossings
  // ----------------------------------------------------------------
  // Pins and the write-pending level into the system domain
  ee_sync #(.W(4)) u_sync_clk (
    .clk (clk),
    .d   ({scl, sda_in, wp, lk.wpend}),
    .q   (cs)
  );

  // Busy, protect pin, enable and reset into the link domain
  ee_sync #(.W(4)) u_sync_scl (
    .clk (scl),
    .d   ({busy, wp, ce, srst}),
    .q   (ls)
  );

  // Straps are quasi-static; resynchronised on the link clock
  ee_sync #(.W(3)) u_sync_sel (
    .clk (scl),
    .d   (dev_sel),
    .q   (sel_s)
  );

  // ----------------------------------------------------------------
  // System domain: stop detection and write timer
  // ----------------------------------------------------------------
  // Start/stop are seen from synchronised lines. A bare start then
  // stop (no falling scl between) is a cancel and starts no write.
  always_comb begin
    next_cq       = cq;
    stop_evt      = cs.scl && cq.scl_p && cs.sda && !cq.sda_p;
    start_evt     = cs.scl && cq.scl_p && !cs.sda && cq.sda_p;
    next_cq.scl_p = cs.scl;
    next_cq.sda_p = cs.sda;
    if (start_evt) begin
      next_cq.fell = 1'b0;
    end else if (cq.scl_p && !cs.scl) begin
      next_cq.fell = 1'b1;
    end
    // Only a clocked write frame ending in stop arms the timer
    tm_start = stop_evt && cq.fell && cs.wpend;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cq <= CK_RST;
    end else if (ce) begin
      cq <= next_cq;
    end
  end

  // Protect pin high during the write ends it at once
  ee_wtimer #(.CYCLES(WR_CYCLES)) u_wtimer (
    .clk   (clk),
    .srst  (srst),
    .ce    (ce),
    .start (tm_start),
    .abort (cs.wp),
    .busy  (busy)
  );

  assign wr_busy = busy;

  // ----------------------------------------------------------------
  // Link domain: protocol on rising scl
  // ----------------------------------------------------------------
  always_comb begin
    next_lk        = lk;
    mem_we         = 1'b0;
    wdata          = {lk.shreg[6:0], sda_in};
    next_lk.sda_hi = sda_in;
    if (dv.st_pend) begin
      // Every start restarts the command, so repeated starts recover
      next_lk.state      = ST_ADDR;
      next_lk.cnt        = 3'h1;
      next_lk.shreg      = {7'h00, sda_in};
      next_lk.first_done = 1'b0;
      next_lk.cancel     = 1'b0;
      next_lk.wpend      = 1'b0;
    end else begin
      // Protect pin watched only after first data lsb
      if (lk.first_done && ls.wp) begin
        next_lk.cancel = 1'b1;
        next_lk.wpend  = 1'b0;
      end
      case (lk.state)
        ST_ADDR: begin
          next_lk.shreg = wdata;
          next_lk.cnt   = lk.cnt + 3'h1;
          if (lk.cnt == `EE_LAST_BIT) begin
            next_lk.state = ST_AACK;
            next_lk.cnt   = 3'h0;
            next_lk.rw    = sda_in;
            // No acknowledge while writing internally
            next_lk.ack   = (lk.shreg[6:3] == DEV_CODE) &&
                            (lk.shreg[2:0] == sel_s) &&
                            !ls.busy;
          end
        end
        ST_AACK: begin
          if (!lk.ack) begin
            next_lk.state = ST_WAIT;
          end else if (lk.rw == `EE_RW_READ) begin
            // Read straight from the address register
            next_lk.state = ST_RDATA;
            next_lk.shreg = mem[lk.addr];
          end else begin
            next_lk.state = ST_WADDR;
          end
        end
        ST_WADDR: begin
          next_lk.shreg = wdata;
          next_lk.cnt   = lk.cnt + 3'h1;
          if (lk.cnt == `EE_LAST_BIT) begin
            // Dummy-write address feeds a following random read
            next_lk.addr  = wdata;
            next_lk.state = ST_WACK;
            next_lk.cnt   = 3'h0;
          end
        end
        ST_WACK: begin
          next_lk.state = ST_WDATA;
        end
        ST_WDATA: begin
          next_lk.shreg = wdata;
          next_lk.cnt   = lk.cnt + 3'h1;
          if (lk.cnt == `EE_LAST_BIT) begin
            // Protect pin first matters at this edge
            if (ls.wp) begin
              next_lk.cancel = 1'b1;
              next_lk.wpend  = 1'b0;
            end else if (!lk.cancel) begin
              mem_we        = 1'b1;
              next_lk.wpend = 1'b1;
            end
            next_lk.first_done = 1'b1;
            next_lk.addr       = lk.addr + 8'h01;
            next_lk.state      = ST_DACK;
            next_lk.cnt        = 3'h0;
          end
        end
        ST_DACK: begin
          next_lk.state = ST_WDATA;
        end
        ST_RDATA: begin
          next_lk.shreg = {lk.shreg[6:0], 1'b0};
          next_lk.cnt   = lk.cnt + 3'h1;
          if (lk.cnt == `EE_LAST_BIT) begin
            next_lk.state = ST_RACK;
            next_lk.cnt   = 3'h0;
            next_lk.addr  = lk.addr + 8'h01;
          end
        end
        ST_RACK: begin
          if (!sda_in) begin
            // Master acknowledged: next byte follows
            next_lk.state = ST_RDATA;
            next_lk.shreg = mem[lk.addr];
          end else begin
            // Nack: ignore all until the next start
            next_lk.state = ST_WAIT;
          end
        end
        ST_IDLE, ST_WAIT: begin
          next_lk.cnt = 3'h0;
        end
        default: begin
          next_lk = LK_RST;
        end
      endcase
    end
  end

  // Link reset comes through the synchroniser, so scl must toggle
  always_ff @(posedge scl) begin
    if (ls.rst) begin
      lk <= LK_RST;
    end else if (ls.ce) begin
      lk <= next_lk;
    end
  end

  // Array has no reset; only written bytes read back defined
  always_ff @(posedge scl) begin
    if (mem_we && ls.ce && !ls.rst) begin
      mem[lk.addr] <= wdata;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: data line drive on falling scl
  // ----------------------------------------------------------------
  // Changing only while scl is low keeps our drive from ever
  // looking like a start or stop to the master.
  always_comb begin
    next_dv         = dv;
    next_dv.st_pend = lk.sda_hi && !sda_in;
    if (next_dv.st_pend) begin
      next_dv.drive_low = 1'b0;
    end else begin
      case (lk.state)
        ST_AACK:          next_dv.drive_low = lk.ack;
        ST_WACK, ST_DACK: next_dv.drive_low = 1'b1;
        ST_RDATA:         next_dv.drive_low = !lk.shreg[7];
        default:          next_dv.drive_low = 1'b0;
      endcase
    end
  end

  always_ff @(negedge scl) begin
    if (ls.rst) begin
      dv <= '0;
    end else if (ls.ce) begin
      dv <= next_dv;
    end
  end

  // Open drain: output value fixed low, only the enable moves
  assign sda_out = 1'b0;
  assign sda_oe  = dv.drive_low;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  busy_no_ack_a: assert property (
    @(posedge scl) disable iff (ls.rst || !ls.ce)
    (lk.state == ST_ADDR && lk.cnt == `EE_LAST_BIT && ls.busy &&
     !dv.st_pend) |=> !lk.ack ##1 !sda_oe)
    else $error("acknowledge given while busy");

  poll_ack_a: assert property (
    @(posedge scl) disable iff (ls.rst || !ls.ce)
    (lk.state == ST_AACK && lk.ack && !dv.st_pend) |-> sda_oe)
    else $error("address not acknowledged low");

  drive_when_a: assert property (
    @(posedge scl) disable iff (ls.rst || !ls.ce)
    sda_oe |-> (lk.state inside {ST_AACK, ST_WACK, ST_DACK, ST_RDATA}))
    else $error("data line driven outside a slot");

  rand_addr_a: assert property (
    @(posedge scl) disable iff (ls.rst || !ls.ce)
    (lk.state == ST_WADDR && lk.cnt == `EE_LAST_BIT && !dv.st_pend)
    |=> lk.addr == $past(wdata))
    else $error("word address not loaded");

  read_inc_a: assert property (
    @(posedge scl) disable iff (ls.rst || !ls.ce)
    (lk.state == ST_RDATA && lk.cnt == `EE_LAST_BIT && !dv.st_pend)
    |=> lk.state == ST_RACK && lk.addr == $past(lk.addr) + 8'h01)
    else $error("read address not advanced");

  seq_read_a: assert property (
    @(posedge scl) disable iff (ls.rst || !ls.ce)
    (lk.state == ST_RACK && !sda_in && !dv.st_pend)
    |=> lk.state == ST_RDATA ##1 sda_oe == !$past(lk.shreg[7]))
    else $error("sequential read did not continue");

  nack_end_a: assert property (
    @(posedge scl) disable iff (ls.rst || !ls.ce)
    (lk.state == ST_RACK && sda_in && !dv.st_pend)
    |=> lk.state == ST_WAIT ##1 !sda_oe)
    else $error("read not ended on nack");

  wp_ignore_a: assert property (
    @(posedge scl) disable iff (ls.rst || !ls.ce)
    (lk.state == ST_WDATA && !lk.first_done) |-> !lk.cancel)
    else $error("protect pin acted before first lsb");

  start_rst_a: assert property (
    @(posedge scl) disable iff (ls.rst || !ls.ce)
    dv.st_pend |=> lk.state == ST_ADDR && !lk.wpend)
    else $error("start did not restart command");

  wp_abort_a: assert property (
    @(posedge clk) disable iff (srst || !ce)
    (busy && cs.wp) |=> !busy)
    else $error("write not aborted by protect pin");

  cancel_a: assert property (
    @(posedge clk) disable iff (srst || !ce)
    (stop_evt && !cq.fell) |=> !$rose(busy))
    else $error("cancelled command started a write");

  cv_rand_read_c: cover property (
    @(posedge scl) lk.state == ST_WACK ##[1:40] lk.state == ST_RDATA);
  cv_seq_read_c: cover property (
    @(posedge scl) lk.state == ST_RACK ##1 lk.state == ST_RDATA);
  cv_busy_nack_c: cover property (
    @(posedge scl) lk.state == ST_AACK && !lk.ack && ls.busy);
  cv_wp_abort_c: cover property (
    @(posedge clk) busy && cs.wp);
endmodule

// >>> ee_wtimer.sv
/*
  Internal write timer: busy for a set number of cycles after start.
  Assumes start is a single-clock signal on clk; abort may be held as a level.
*/
`timescale 1ns/100ps
`include "ee_regs.svh"

module ee_wtimer import ee_pkg::*; #(
  parameter int unsigned CYCLES = `EE_WR_CYCLES
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic start,
  input  wire logic abort,
  output logic      busy
);
  localparam int CW = $clog2(CYCLES + 1);

  // ----------------------------------------------------------------
  // Timer state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic          busy;
    logic [CW-1:0] cnt;
  } ee_tm_t;

  ee_tm_t tm;       // Current
  ee_tm_t next_tm;  // Next

  // Abort wins over expiry; a start while busy is ignored
  always_comb begin
    next_tm = tm;
    if (start && !tm.busy) begin
      next_tm.busy = 1'b1;
      next_tm.cnt  = CW'(CYCLES - 1);
    end else if (tm.busy) begin
      if (abort || tm.cnt == '0) begin
        next_tm.busy = 1'b0;
        next_tm.cnt  = '0;
      end else begin
        next_tm.cnt = tm.cnt - CW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tm <= '0;
    end else if (ce) begin
      tm <= next_tm;
    end
  end

  assign busy = tm.busy;
endmodule

// >>> serial_eeprom_read_and_cancel_tb.sv
/*
  Self-checking bench of the EEPROM target: reads, polling, cancels.
  Assumes ee_pkg and the master model are compiled before it.
*/
`timescale 1ns/100ps

module serial_eeprom_read_and_cancel_tb import ee_pkg::*;;
  localparam logic [3:0] DEV_CODE_TB = 4'h5;  // Arbitrary type code
  localparam int         WR_CYC      = 200;   // Short write time keeps the run brief

  logic       clk;          // 200 MHz system clock
  logic       srst;         // Synchronous reset
  logic       ce;           // Clock enable, tied high
  logic       wp;           // Write protect pin
  logic [2:0] dev_sel;      // Select straps
  logic       sda_out;      // Target data value, open drain
  logic       sda_oe;       // Target pulls data low
  logic       wr_busy;      // Internal write running
  logic       m_scl;        // Master clock
  logic       m_oe;         // Master pulls data low
  wire        sda_w;        // Wire with pull-up
  logic [7:0] mem [256];    // Shadow of bytes written
  logic [7:0] a;            // Current word address
  logic [7:0] d;            // Read byte
  logic       ack;          // Answer bit
  int         n_errors;     // Mismatches
  int         checks_done;  // Comparisons made
  int         cyc;          // Cycle counter for the timeout
  int         tries;        // Polls needed
  int         n;            // Bytes in a frame
  integer     seed;         // Random seed

  // Either party pulling low wins, released means high
  assign sda_w = (sda_oe ? sda_out : 1'b1) & ~m_oe;

  always #2.5 clk = ~clk;

  ee_top #(.WR_CYCLES(WR_CYC), .DEV_CODE(DEV_CODE_TB)) u_dut (
    .clk(clk), .srst(srst), .ce(ce), .scl(m_scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .wp(wp), .dev_sel(dev_sel), .wr_busy(wr_busy)
  );

  ee_mst_model u_mst (.scl(m_scl), .sda_oe(m_oe), .sda(sda_w));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] sa(input logic rw);
    return {DEV_CODE_TB, dev_sel, rw};
  endfunction

  task automatic tally_and_finish();
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Byte results: read data against the shadow array
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    // An unknown expectation means the scenario read an unwritten byte
    if (got !== exp || $isunknown(exp)) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bit results: acknowledge answers, the busy level and the data output value
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Start plus slave address, acknowledge expected low
  task automatic adr(input logic rw);
    u_mst.start();
    u_mst.wbyte(sa(rw), ack);
    chk_bit(ack, 1'b0);
  endtask

  // Write n random bytes; protect pin dropped before the first data byte
  task automatic wr(input logic [7:0] wa, input int cnt);
    logic [7:0] b;
    adr(1'b0);
    u_mst.wbyte(wa, ack);
    chk_bit(ack, 1'b0);
    @(negedge clk) wp = 1'b0;
    for (int i = 0; i < cnt; i++) begin
      b = $random(seed);
      u_mst.wbyte(b, ack);
      chk_bit(ack, 1'b0);
      mem[wa + i[7:0]] = b;
    end
    u_mst.stop();
  endtask

  // Mode 0 random read, 1 after an acked write address, 2 current read
  task automatic rd(input int mode, input logic [7:0] ra, input int cnt);
    if (mode == 0) adr(1'b0);
    if (mode < 2) begin
      u_mst.wbyte(ra, ack);
      chk_bit(ack, 1'b0);
    end
    adr(1'b1);
    for (int i = 0; i < cnt; i++) begin
      u_mst.rbyte(i == cnt - 1, d);
      chk(d, mem[ra + i[7:0]]);
    end
    u_mst.stop();
  endtask

  // Poll with a write address until acked; leaves the bus addressed
  task automatic poll();
    tries = 0;
    ack = 1'b1;
    while (ack && tries < 60) begin
      u_mst.start();
      u_mst.wbyte(sa(1'b0), ack);
      if (ack) u_mst.stop();
      tries++;
    end
    chk_bit(ack, 1'b0);
  endtask

  task automatic busy_is(input logic exp);
    repeat (20) @(negedge clk);
    chk_bit(wr_busy, exp);
  endtask

  // ----------------------------------------------------------------
  // Timeout, generous against the roughly 3300 cycles expected
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h72f58a7b;
    clk = 1'b0;
    srst = 1'b1;
    ce = 1'b1;
    wp = 1'b0;
    dev_sel = $random(seed);
    u_mst.clocks(4);  // Link reset needs clock edges too
    @(negedge clk) srst = 1'b0;
    u_mst.clocks(3);
    chk_bit(wr_busy, 1'b0);
    // Protect pin high in the address phase does not stop the write
    a = $random(seed);
    @(negedge clk) wp = 1'b1;
    wr(a, 5);
    busy_is(1'b1);
    u_mst.start();
    u_mst.wbyte(sa(1'b0), ack);
    u_mst.stop();
    chk_bit(ack, 1'b1);
    poll();
    rd(1, a, 4);
    rd(2, a + 8'h04, 1);
    chk_bit(sda_out, 1'b0);
    // Random frames of two to five bytes: one random read, then a
    // current read of the rest, so no read runs past written bytes
    repeat (3) begin
      a = $random(seed);
      n = 2 + ($random(seed) & 3);
      wr(a, n);
      poll();
      rd(1, a, 1);
      rd(2, a + 8'h01, n - 1);
    end
    // Cancel inside a write frame: no write time
    adr(1'b0);
    u_mst.wbyte(a + 8'h10, ack);
    u_mst.wbyte($random(seed), ack);
    u_mst.cancel();
    busy_is(1'b0);
    rd(0, a, 1);
    // Protect pin during the write time ends it at once
    wr(a ^ 8'h80, 1);
    busy_is(1'b1);
    @(negedge clk) wp = 1'b1;
    repeat (10) @(negedge clk);
    chk_bit(wr_busy, 1'b0);
    u_mst.start();
    u_mst.wbyte(sa(1'b0), ack);
    chk_bit(ack, 1'b0);
    u_mst.stop();
    @(negedge clk) wp = 1'b0;
    // Nine starts while the target sends data, then a normal read;
    // the byte after a is written, so the dummy clocks shift known bits
    adr(1'b0);
    u_mst.wbyte(a, ack);
    adr(1'b1);
    u_mst.rbyte(1'b0, d);
    chk(d, mem[a]);
    repeat (9) u_mst.start();
    u_mst.stop();
    rd(0, a, 1);
    tally_and_finish();
  end
endmodule
